// ===== src/fbp_port.sv
module fbp_port
   import fbp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic tx_oe,
   output logic irq
);
   // =====================================================
   // types and state
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000, RX_DA = 3'b001, RX_SA = 3'b010,
      RX_LEN = 3'b011, RX_DATA = 3'b100, RX_FCS = 3'b101,
      RX_END = 3'b110
   } fbp_rx_e;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000, TX_SD = 3'b001, TX_DA = 3'b010,
      TX_SA = 3'b011, TX_LEN = 3'b100, TX_DATA = 3'b101,
      TX_FCS = 3'b110, TX_ED = 3'b111
   } fbp_tx_e;

   typedef struct packed {
      logic [4:0] ctrl;
      fbp_cfg_s act;
      fbp_cfg_s stg;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic irq;
      logic oe;
      logic [31:0] prdata;
      logic [7:0][7:0] txbuf;
      logic [7:0][7:0] rxbuf;
      logic [2:0] rd_idx;
      logic [2:0] conn;
      logic reply;
      fbp_rx_e rx_st;
      logic [7:0] rx_da, rx_sa, rx_len, rx_idx, rx_sum;
      logic rx_bad;
      logic [6:0] info_sa;
      logic [7:0] info_len;
      fbp_tx_e tx_st;
      logic [6:0] tx_da;
      logic [3:0] tx_len;
      logic [3:0] tx_idx;
      logic [7:0] tx_sum;
      logic go;
      logic [7:0] tx_byte;
   } fbp_port_s;

   fbp_port_s s, n;
   logic [ST_W-1:0] ev;
   logic [31:0] rd_mux;
   logic [15:0] div;
   logic [7:0] rx_byte;
   logic rx_vld, rx_perr, tx_rdy, wr_acc, rd_acc, master_on, load_wr;
   logic cfg_ok, cmd_ok, conn_ok, end_bad, for_me, frame_end;

   // =====================================================
   // bus slave: no wait states, error on unmapped offsets
   function automatic logic fbp_mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= OFF_CONN);
   endfunction : fbp_mapped

   assign wr_acc = psel && penable && pwrite && fbp_mapped(paddr);
   assign rd_acc = psel && penable && !pwrite && fbp_mapped(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !fbp_mapped(paddr);
   assign prdata = s.prdata;
   assign irq = s.irq;
   assign tx_oe = s.oe;

   // one rate drives both directions, so the link stays on the network rate
   assign div = fbp_baud_div(s.act.baud);
   assign master_on = s.ctrl[CTRL_RUN] && s.ctrl[CTRL_MASTER];
   assign load_wr = wr_acc && (paddr == OFF_CTRL) && pwdata[CTRL_LOAD];
   // staged set is checked against the mode being written with it
   assign cfg_ok = (s.stg.addr <= MAX_ADDR)
                   && fbp_baud_ok(s.stg.baud, pwdata[CTRL_USER], pwdata[CTRL_CONN]);
   // request needs master mode; reply needs a pending request
   assign cmd_ok = (s.tx_st == TX_IDLE) && (pwdata[11:8] <= MAX_LEN)
                   && (pwdata[TXCMD_REQ] ? (master_on && !s.ctrl[CTRL_MULTI]) : s.reply);
   assign conn_ok = s.ctrl[CTRL_CONN] && (s.conn < MAX_CONN)
                    && !(s.ctrl[CTRL_MULTI] && master_on);
   assign frame_end = rx_vld && (s.rx_st == RX_END);
   assign end_bad = s.rx_bad || rx_perr || (rx_byte != ED_CHAR);
   // multipoint traffic is ignored while this port is master
   assign for_me = (s.rx_da == {1'b0, s.act.addr}) && !(s.ctrl[CTRL_MULTI] && master_on);

   // read data is captured in the setup cycle so prdata is a flop
   always_comb
   begin
      case (paddr)
         OFF_CTRL: rd_mux = {27'h0000000, s.ctrl};
         OFF_CFG: rd_mux = {20'h00000, s.stg.baud, 1'b0, s.stg.addr};
         OFF_ACTIVE: rd_mux = {20'h00000, s.act.baud, 1'b0, s.act.addr};
         OFF_STATUS: rd_mux = {27'h0000000, s.status};
         OFF_MASK: rd_mux = {27'h0000000, s.mask};
         OFF_TXCMD: rd_mux = {30'h00000000, s.reply, s.tx_st != TX_IDLE};
         OFF_RXINFO: rd_mux = {16'h0000, s.info_len, 1'b0, s.info_sa};
         OFF_RXBUF: rd_mux = {24'h000000, s.rxbuf[s.rd_idx]};
         OFF_CONN: rd_mux = {29'h00000000, s.conn};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // =====================================================
   // next state
   always_comb
   begin
      n = s;
      ev = '0;
      n.go = 1'b0;
      if (psel && !penable)
         n.prdata = rd_mux;
      // only bits shown by the read are cleared, so a later event survives
      if (rd_acc && paddr == OFF_STATUS)
         n.status = s.status & ~s.prdata[ST_W-1:0];
      if (wr_acc)
      begin
         case (paddr)
            OFF_CTRL:
            begin
               n.ctrl = pwdata[4:0];
               if (pwdata[CTRL_LOAD])
               begin
                  if (cfg_ok)
                     n.act = s.stg;
                  else
                     ev[ST_CFGERR] = 1'b1;
               end
            end
            OFF_CFG:
            begin
               n.stg.addr = pwdata[6:0];
               n.stg.baud = pwdata[11:8];
            end
            OFF_MASK: n.mask = pwdata[ST_W-1:0];
            OFF_TXCMD:
            begin
               if (cmd_ok)
               begin
                  n.tx_da = pwdata[6:0];
                  n.tx_len = pwdata[11:8];
                  n.tx_st = TX_SD;
                  if (!pwdata[TXCMD_REQ])
                     n.reply = 1'b0;
               end
               else
                  ev[ST_REFUSED] = 1'b1;
            end
            OFF_TXBUF: n.txbuf[pwdata[10:8]] = pwdata[7:0];
            OFF_RXBUF: n.rd_idx = pwdata[2:0];
            OFF_CONN:
            begin
               if (pwdata[0])
               begin
                  if (conn_ok)
                     n.conn = s.conn + 3'h1;
                  else
                     ev[ST_REFUSED] = 1'b1;
               end
               else if (pwdata[1] && s.conn != 3'h0)
                  n.conn = s.conn - 3'h1;
            end
            default: ;
         endcase
      end

      // receive parser; payload lands in place, so a bad frame may overwrite it
      if (rx_vld)
      begin
         n.rx_bad = s.rx_bad || rx_perr;
         unique case (s.rx_st)
            RX_IDLE:
               if (rx_byte == SD_CHAR && !rx_perr)
               begin
                  n.rx_st = RX_DA;
                  n.rx_bad = 1'b0;
               end
            RX_DA:
            begin
               n.rx_da = rx_byte;
               n.rx_sum = rx_byte;
               n.rx_st = RX_SA;
            end
            RX_SA:
            begin
               n.rx_sa = rx_byte;
               n.rx_sum = s.rx_sum + rx_byte;
               n.rx_st = RX_LEN;
            end
            RX_LEN:
            begin
               n.rx_len = rx_byte;
               n.rx_idx = 8'h00;
               n.rx_sum = s.rx_sum + rx_byte;
               n.rx_bad = s.rx_bad || rx_perr || (rx_byte > {4'h0, MAX_LEN});
               n.rx_st = (rx_byte == 8'h00) ? RX_FCS : RX_DATA;
            end
            RX_DATA:
            begin
               if (s.rx_idx < {4'h0, MAX_LEN})
                  n.rxbuf[s.rx_idx[2:0]] = rx_byte;
               n.rx_idx = s.rx_idx + 8'h01;
               n.rx_sum = s.rx_sum + rx_byte;
               if (s.rx_idx + 8'h01 == s.rx_len)
                  n.rx_st = RX_FCS;
            end
            RX_FCS:
            begin
               n.rx_bad = s.rx_bad || rx_perr || (rx_byte != s.rx_sum);
               n.rx_st = RX_END;
            end
            RX_END:
            begin
               n.rx_st = RX_IDLE;
               // a damaged destination cannot be trusted, so any bad frame flags
               if (end_bad)
                  ev[ST_RXERR] = 1'b1;
               else if (for_me)
               begin
                  ev[ST_RXOK] = 1'b1;
                  n.info_sa = s.rx_sa[6:0];
                  n.info_len = s.rx_len;
                  n.reply = 1'b1;
               end
            end
            default: n.rx_st = RX_IDLE;
         endcase
      end

      // frame builder hands one byte per free character slot
      if (s.tx_st != TX_IDLE && tx_rdy && !s.go)
      begin
         n.go = 1'b1;
         unique case (s.tx_st)
            TX_IDLE: ;
            TX_SD:
            begin
               n.tx_byte = SD_CHAR;
               n.tx_st = TX_DA;
            end
            TX_DA:
            begin
               n.tx_byte = {1'b0, s.tx_da};
               n.tx_sum = {1'b0, s.tx_da};
               n.tx_st = TX_SA;
            end
            TX_SA:
            begin
               n.tx_byte = {1'b0, s.act.addr};
               n.tx_sum = s.tx_sum + {1'b0, s.act.addr};
               n.tx_st = TX_LEN;
            end
            TX_LEN:
            begin
               n.tx_byte = {4'h0, s.tx_len};
               n.tx_sum = s.tx_sum + {4'h0, s.tx_len};
               n.tx_idx = 4'h0;
               n.tx_st = (s.tx_len == 4'h0) ? TX_FCS : TX_DATA;
            end
            TX_DATA:
            begin
               n.tx_byte = s.txbuf[s.tx_idx[2:0]];
               n.tx_sum = s.tx_sum + s.txbuf[s.tx_idx[2:0]];
               n.tx_idx = s.tx_idx + 4'h1;
               if (s.tx_idx + 4'h1 == s.tx_len)
                  n.tx_st = TX_FCS;
            end
            TX_FCS:
            begin
               n.tx_byte = s.tx_sum;
               n.tx_st = TX_ED;
            end
            TX_ED:
            begin
               n.tx_byte = ED_CHAR;
               n.tx_st = TX_IDLE;
               ev[ST_TXDONE] = 1'b1;
            end
         endcase
      end

      // set wins over a clear in the same cycle
      n.status = n.status | ev;
      n.irq = |(n.status & n.mask);
      // go in flight covers the gap before the serializer reports busy
      n.oe = (n.tx_st != TX_IDLE) || n.go || s.go || !tx_rdy;
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         s <= '0;
         s.act.addr <= DEF_ADDR;
         s.act.baud <= BAUD_9K6;
         s.stg.addr <= DEF_ADDR;
         s.stg.baud <= BAUD_9K6;
      end
      else
         s <= n;
   end

   // =====================================================
   // character engines
   fbp_rx u_rx (
      .clk_sys(clk_sys),
      .reset(reset),
      .rx_pin(rx_pin),
      .div(div),
      .data(rx_byte),
      .valid(rx_vld),
      .err(rx_perr)
   );

   fbp_tx u_tx (
      .clk_sys(clk_sys),
      .reset(reset),
      .start(s.go),
      .data(s.tx_byte),
      .div(div),
      .line(tx_pin),
      .rdy(tx_rdy)
   );

   // =====================================================
   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_addr_in_range: assert property (s.act.addr <= MAX_ADDR)
      else $error("active address above limit");
   a_reset_defaults: assert property ($past(reset) |->
         s.act.addr == DEF_ADDR && s.act.baud == BAUD_9K6)
      else $error("wrong configuration after reset");
   a_load_only: assert property (!$stable(s.act) |-> $past(load_wr) && $past(cfg_ok))
      else $error("active configuration changed without load");
   a_cfg_reject: assert property (load_wr && !cfg_ok |=> $stable(s.act) && s.status[ST_CFGERR])
      else $error("illegal configuration not rejected");
   a_slave_quiet: assert property ($past(s.tx_st) == TX_IDLE && s.tx_st != TX_IDLE |->
         $past(cmd_ok) && $past(wr_acc))
      else $error("transmission started without cause");
   a_conn_limit: assert property (s.conn <= MAX_CONN)
      else $error("connection count above limit");
   a_bad_flagged: assert property (frame_end && end_bad |=> s.status[ST_RXERR] && !$rose(s.reply))
      else $error("bad frame not flagged or answered");
   a_multi_silent: assert property (frame_end && s.ctrl[CTRL_MULTI] && master_on |=>
         !$rose(s.reply))
      else $error("multipoint frame accepted while master");
   a_irq_follows: assert property (s.status[ST_RXOK] && s.mask[ST_RXOK] |-> irq)
      else $error("interrupt missing");
   a_oe_covers: assert property (!tx_rdy |-> tx_oe)
      else $error("line driver off while a character is sent");
endmodule : fbp_port

// ===== src/fbp_pkg.sv
// Notes on behaviour
// - standard rates 9.6 to 187.5 kbaud; connection variant only 9.6, 19.2, 187.5
// - user-defined framing mode accepts rates from 1200 baud to 115.2 kbaud
// - station address lies in 0 to 126 and is unique on the network
// - each port instance keeps its own independently loaded station address
// - after reset the port runs at 9.6 kbaud with station address 2
// - rate and address are staged and take effect only when loaded
// - every station on a network uses the same baud rate
// - character is start bit, eight data bits, even parity, one stop bit
// - frames carry start and end characters, addresses, length and checksum
// - protocols may share the network when all use one baud rate
// - as slave the port transmits only in answer to a master request
// - master only while running and master mode enabled by software
// - while master outside multipoint mode, the port still answers requests from other masters
// - connection variant allows at most 4 connections; further attempts refused
// - multipoint mode: no master-initiated traffic and no answers while master
package fbp_pkg;
   // =====================================================
   // clock and baud table
   localparam int CLK_HZ = 50_000_000;
   localparam int RATE_HZ [0:8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600,
                                    115200, 187500};
   localparam logic [3:0] BAUD_1K2 = 4'h0;
   localparam logic [3:0] BAUD_9K6 = 4'h3;
   localparam logic [3:0] BAUD_19K2 = 4'h4;
   localparam logic [3:0] BAUD_115K2 = 4'h7;
   localparam logic [3:0] BAUD_187K5 = 4'h8;
   // =====================================================
   // register map
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CFG = 8'h04;
   localparam logic [7:0] OFF_ACTIVE = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_MASK = 8'h10;
   localparam logic [7:0] OFF_TXCMD = 8'h14;
   localparam logic [7:0] OFF_TXBUF = 8'h18;
   localparam logic [7:0] OFF_RXINFO = 8'h1C;
   localparam logic [7:0] OFF_RXBUF = 8'h20;
   localparam logic [7:0] OFF_CONN = 8'h24;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_MASTER = 1;
   localparam int CTRL_USER = 2;
   localparam int CTRL_CONN = 3;
   localparam int CTRL_MULTI = 4;
   localparam int CTRL_LOAD = 5;
   localparam int TXCMD_REQ = 12;
   localparam int ST_W = 5;
   localparam int ST_RXOK = 0;
   localparam int ST_RXERR = 1;
   localparam int ST_TXDONE = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_CFGERR = 4;
   // =====================================================
   // reset values and limits
   localparam logic [6:0] DEF_ADDR = 7'h02;
   localparam logic [6:0] MAX_ADDR = 7'h7E;
   localparam logic [2:0] MAX_CONN = 3'h4;
   localparam logic [3:0] MAX_LEN = 4'h8;
   localparam logic [7:0] SD_CHAR = 8'h68;
   localparam logic [7:0] ED_CHAR = 8'h16;

   typedef struct packed {
      logic [6:0] addr;
      logic [3:0] baud;
   } fbp_cfg_s;

   // bit period in clocks, rounded down; unknown codes fall back to 9.6 kbaud
   function automatic logic [15:0] fbp_baud_div(input logic [3:0] sel);
      int r;
      r = (sel <= BAUD_187K5) ? RATE_HZ[sel] : RATE_HZ[BAUD_9K6];
      return 16'(CLK_HZ / r);
   endfunction : fbp_baud_div

   // legal rate set depends on the operating mode
   function automatic logic fbp_baud_ok(input logic [3:0] sel, input logic user,
                                        input logic conn);
      if (user)
         return sel <= BAUD_115K2;
      if (conn)
         return (sel == BAUD_9K6) || (sel == BAUD_19K2) || (sel == BAUD_187K5);
      return (sel >= BAUD_9K6) && (sel <= BAUD_187K5);
   endfunction : fbp_baud_ok
endpackage : fbp_pkg

// ===== src/fbp_tx.sv
module fbp_tx
   import fbp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic start,
   input wire logic [7:0] data,
   input wire logic [15:0] div,
   output logic line,
   output logic rdy
);
   // =====================================================
   // state
   typedef struct packed {
      logic busy;
      logic [15:0] cnt;
      logic [3:0] bitn;
      logic [10:0] sh;
      logic line;
   } fbp_tx_s;
   fbp_tx_s s;
   fbp_tx_s n;

   assign rdy = !s.busy;
   assign line = s.line;

   // shift out start, data lsb first, parity, stop
   always_comb
   begin
      n = s;
      if (!s.busy)
      begin
         if (start)
         begin
            n.busy = 1'b1;
            n.sh = {1'b1, ^data, data, 1'b0}; // even parity
            n.cnt = div - 16'h0001;
            n.bitn = 4'h0;
            n.line = 1'b0;
         end
      end
      else if (s.cnt != 16'h0000)
         n.cnt = s.cnt - 16'h0001;
      else if (s.bitn == 4'hA)
         n.busy = 1'b0;
      else
      begin
         n.bitn = s.bitn + 4'h1;
         n.cnt = div - 16'h0001;
         n.sh = {1'b1, s.sh[10:1]};
         n.line = s.sh[1];
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         s <= '0;
         s.line <= 1'b1;
      end
      else
         s <= n;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_start_bit_low: assert property ($rose(s.busy) |-> !line)
      else $error("start bit not low");
   a_stop_bit_high: assert property (s.busy && s.bitn == 4'hA |-> line)
      else $error("stop bit not high");
endmodule : fbp_tx

// ===== src/fbp_rx.sv
module fbp_rx
   import fbp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic rx_pin,
   input wire logic [15:0] div,
   output logic [7:0] data,
   output logic valid,
   output logic err
);
   // =====================================================
   // state
   typedef struct packed {
      logic s1;
      logic s2;
      logic busy;
      logic [15:0] cnt;
      logic [3:0] bitn;
      logic [9:0] sh;
      logic [7:0] data;
      logic valid;
      logic err;
   } fbp_rx_s;
   fbp_rx_s s;
   fbp_rx_s n;
   logic [9:0] sh_v;

   assign data = s.data;
   assign valid = s.valid;
   assign err = s.err;

   // mid-bit sampling; a start bit that is high at its middle is a glitch
   always_comb
   begin
      sh_v = {s.s2, s.sh[9:1]};
      n = s;
      n.s1 = rx_pin;
      n.s2 = s.s1;
      n.valid = 1'b0;
      n.err = 1'b0;
      if (!s.busy)
      begin
         if (!s.s2)
         begin
            n.busy = 1'b1;
            n.cnt = {1'b0, div[15:1]};
            n.bitn = 4'h0;
         end
      end
      else if (s.cnt != 16'h0000)
         n.cnt = s.cnt - 16'h0001;
      else
      begin
         n.cnt = div - 16'h0001;
         n.bitn = s.bitn + 4'h1;
         if (s.bitn == 4'h0)
            n.busy = !s.s2;
         else
            n.sh = sh_v;
         if (s.bitn == 4'hA)
         begin
            n.busy = 1'b0;
            n.valid = 1'b1;
            n.data = sh_v[7:0];
            n.err = (^sh_v[8:0]) | !sh_v[9]; // parity or framing fault
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         s <= '0;
         s.s1 <= 1'b1;
         s.s2 <= 1'b1;
      end
      else
         s <= n;
   end
endmodule : fbp_rx

// ===== bench/fbp_station.sv
// =====================================================
// far-side station: drives frames onto the shared line
module fbp_station
(
   input wire logic clk_sys,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ns;
   // rate code 8, floor(50e6/187500); both ends share it
   localparam int BIT_CLK = 266;

   // line rests high between frames, like a pulled-up bus
   initial line = 1'b1;

   // one character, lsb first, even parity
   task automatic send_char(input logic [7:0] c);
      logic [10:0] f;
      f = {1'b1, ^c, c, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         line <= f[i];
         repeat (BIT_CLK) @(posedge clk_sys);
      end
   endtask : send_char

   // one of at most 32 masters polls the slave; bad flips the checksum
   task automatic send_frame(input logic [6:0] da, input logic [6:0] sa, input logic bad);
      logic [7:0] fcs;
      fcs = {1'b0, da} + {1'b0, sa};
      send_char(8'h68);
      send_char({1'b0, da});
      send_char({1'b0, sa});
      send_char(8'h00);
      send_char(fcs ^ {7'h00, bad});
      send_char(8'h16);
   endtask : send_frame
endmodule : fbp_station

// ===== bench/fieldbus_port_baud_address_tb.sv
module fieldbus_port_baud_address_tb;
   import fbp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin fails++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, rx_pin, tx_pin, tx_oe, irq;
   logic line, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] src;
   int fails, check_count, st_m, seed;

   // shared line: port and station both pull low, idle high
   assign rx_pin = line & (tx_oe ? tx_pin : 1'b1);
   fbp_port u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe), .irq(irq));
   fbp_station u_stn (.clk_sys(clk_sys), .line(line));

   // =====================================================
   // clock and bus tasks
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic give_verdict;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   // a spent wait bound is a mismatch and ends the run
   task automatic tmo(input int n, input int lim);
      if (n >= lim)
      begin
         fails++;
         give_verdict();
      end
   endtask : tmo

   // one transfer; idle edge after keeps drivers single per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      tmo(n, 50);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, x, rd)
   endtask : rc

   // status model: read returns and clears accumulated events
   task automatic rs;
      rc(OFF_STATUS, 32'(st_m), "status");
      st_m = 0;
   endtask : rs

   // decode the port's frame off tx_pin against the model queue; one bit is 266 clocks
   task automatic tx_check;
      int n;
      logic [7:0] q [$];
      logic [10:0] f;
      logic [10:0] x;
      q = '{8'h68, {1'b0, src}, 8'h05, 8'h00, {1'b0, src} + 8'h05, 8'h16};
      repeat (4) @(posedge clk_sys);
      `CHK("tx_oe", 1'b1, tx_oe)
      foreach (q[k])
      begin
         n = 0;
         while (tx_pin !== 1'b0 && n < 4000)
         begin
            @(posedge clk_sys);
            n++;
         end
         tmo(n, 4000);
         // sample every bit near its middle
         for (int i = 0; i < 11; i++)
         begin
            repeat ((i == 0) ? 133 : 266) @(posedge clk_sys);
            f[i] = tx_pin;
         end
         x = {1'b1, ^q[k], q[k], 1'b0};
         `CHK("tx_char", x, f)
      end
      n = 0;
      while (tx_oe !== 1'b0 && n < 400)
      begin
         @(posedge clk_sys);
         n++;
      end
      tmo(n, 400);
      st_m = 4;
      rs();
   endtask : tx_check

   function automatic logic legal(input int m, input int c);
      if (m == 1)
         return c <= 7;
      if (m == 2)
         return c == 3 || c == 4 || c == 8;
      return c >= 3 && c <= 8;
   endfunction : legal

   // =====================================================
   // main sequence
   initial
   begin
      logic [31:0] cv [3];
      cv = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0013};
      seed = 38106;
      {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      fails = 0;
      check_count = 0;
      st_m = 0;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rc(OFF_ACTIVE, 32'h0000_0302, "active");
      rc(OFF_CFG, 32'h0000_0302, "cfg");
      apb(1'b0, 8'h28, 32'h0000_0000);
      `CHK("slverr", 1'b1, e)
      wr(OFF_CFG, 32'h0000_0805);
      rc(OFF_ACTIVE, 32'h0000_0302, "staged");
      $display("test reset done");
      // every rate code under every mode; a refusal sets the config flag
      for (int m = 0; m < 3; m++)
         for (int c = 0; c < 9; c++)
         begin
            wr(OFF_CFG, 32'((c << 8) | 5));
            wr(OFF_CTRL, 32'(((m == 0) ? 0 : (2 << m)) | 32));
            st_m = legal(m, c) ? 0 : 16;
            rs();
         end
      wr(OFF_CFG, 32'h0000_087F);
      wr(OFF_CTRL, 32'h0000_0020);
      st_m = 16;
      rs();
      wr(OFF_CFG, 32'h0000_0805);
      wr(OFF_CTRL, 32'h0000_0020);
      rc(OFF_ACTIVE, 32'h0000_0805, "loaded");
      $display("test rates done");
      wr(OFF_CTRL, 32'h0000_0008);
      repeat (5) wr(OFF_CONN, 32'h0000_0001);
      rc(OFF_CONN, 32'h0000_0004, "conns");
      st_m = 8;
      rs();
      wr(OFF_CONN, 32'h0000_0002);
      rc(OFF_CONN, 32'h0000_0003, "close");
      $display("test conn done");
      src = 7'(10 + ($random(seed) & 63));
      for (int i = 0; i < 3; i++)
      begin
         wr(OFF_CTRL, cv[i]);
         wr(OFF_TXCMD, 32'h0000_1000 | 32'(src));
         st_m = 8;
         rs();
      end
      wr(OFF_CTRL, 32'h0000_0003);
      wr(OFF_TXCMD, 32'h0000_1000 | 32'(src));
      tx_check();
      $display("test master done");
      wr(OFF_MASK, 32'h0000_001F);
      u_stn.send_frame(7'h05, src, 1'b0);
      repeat (20) @(posedge clk_sys);
      `CHK("irq", 1'b1, irq)
      rc(OFF_TXCMD, 32'h0000_0002, "pending");
      rc(OFF_RXINFO, 32'(src), "rxinfo");
      st_m = 1;
      rs();
      wr(OFF_TXCMD, 32'(src));
      tx_check();
      $display("test reply done");
      wr(OFF_MASK, 32'h0000_001D);
      u_stn.send_frame(7'h05, src, 1'b1);
      repeat (20) @(posedge clk_sys);
      `CHK("irq_masked", 1'b0, irq)
      rc(OFF_TXCMD, 32'h0000_0000, "no_reply");
      st_m = 2;
      rs();
      $display("test error done");
      // a master in multipoint mode ignores even a good frame for it
      wr(OFF_CTRL, 32'h0000_0013);
      u_stn.send_frame(7'h05, src, 1'b0);
      repeat (20) @(posedge clk_sys);
      rc(OFF_TXCMD, 32'h0000_0000, "multi_quiet");
      st_m = 0;
      rs();
      $display("test multipoint done");
      give_verdict();
   end
endmodule : fieldbus_port_baud_address_tb
